// File: shared/adc_cfg_pkg.sv
// Package: setup byte layout, pair register layout, timing and types
package adc_cfg_pkg;

  // ==========================================================
  // Input byte decode
  // ==========================================================
  localparam int CMD_HI_BIT = 7;
  localparam int CMD_SETUP_BIT = 6;
  localparam int CLK_HI_BIT = 5;
  localparam int CLK_LO_BIT = 4;
  localparam int REF_HI_BIT = 3;
  localparam int REF_LO_BIT = 2;
  localparam int PAIR_HI_BIT = 1;
  localparam int PAIR_LO_BIT = 0;

  // ==========================================================
  // Field codes and reset values
  // ==========================================================
  localparam logic [1:0] CLK_INT_INT = 2'h0;
  localparam logic [1:0] CLK_INT_EXT = 2'h1;
  localparam logic [1:0] CLK_INT_SER = 2'h2;
  localparam logic [1:0] CLK_SER_SER = 2'h3;
  localparam logic [1:0] REF_INT_AUTO = 2'h0;
  localparam logic [1:0] REF_EXT_SE = 2'h1;
  localparam logic [1:0] REF_INT_ON = 2'h2;
  localparam logic [1:0] REF_EXT_DIFF = 2'h3;
  localparam logic [1:0] PAIR_UNI = 2'h2;
  localparam logic [1:0] PAIR_BI = 2'h3;
  localparam logic [7:0] SETUP_RESET = 8'h60;
  localparam logic [7:0] PAIR_RESET = 8'h00;
  localparam int NUM_PAIRS = 8;

  // ==========================================================
  // Serial frame and timing
  // ==========================================================
  localparam int FRAME_BITS = 16;
  localparam int RESULT_BITS = 12;
  localparam int LEAD_ZEROS = 4;
  localparam int CLK_HZ = 40_000_000;
  // Reference wake-up time, microseconds
  localparam int REF_WAKE_US = 65;
  localparam int REF_WAKE_CYC = (REF_WAKE_US * CLK_HZ + 999_999) / 1_000_000;
  // Temperature scaling: Kelvin to Celsius at 1/8 degree a code
  localparam int TEMP_STEPS_PER_DEG = 8;
  localparam int KELVIN_OFFSET_C = 273;
  localparam logic [11:0] TEMP_OFFSET =
    12'(KELVIN_OFFSET_C * TEMP_STEPS_PER_DEG);

  // ==========================================================
  // Types
  // ==========================================================
  typedef struct packed {
    logic [1:0] clock_mode;
    logic [1:0] vref_select;
    logic [1:0] pair_reg_select;
  } setup_s;

  typedef struct packed {
    logic [11:0] code;
    logic is_bipolar;
  } result_s;

  typedef enum logic [2:0] {
    RX_CMD = 3'b001,
    RX_PAIR = 3'b010,
    RX_SKIP = 3'b100
  } rx_state_e;

endpackage

// File: rtl/adc_setup_and_pair_config.sv
// Setup byte decode, pair configuration and result framing
// Notes on behaviour
// - Byte with bit 7 low and bit 6 high is a setup byte.
// - Clock mode high bit resets to one, so power-up mode is 10.
// - Modes 00/01 use internal clock and dedicate the convert-start pin.
// - Mode 11 uses serial clock for conversion and acquisition, max 4.8MHz.
// - Reference 00: internal, off after scan, wake-up delay before next.
// - Reference 10: internal, always on, no wake-up delay.
// - 01 external single-ended; 11 external differential with negative pin.
// - Pair select high bit zero: no data byte, pair registers kept.
// - Pair select 10: next byte goes to unipolar pair register.
// - Pair select 11: next byte goes to bipolar pair register.
// - Unipolar bit set makes pair differential unipolar, bit 7 = inputs 0/1.
// - Bipolar bit set makes pair differential bipolar, bit 7 = inputs 0/1.
// - Temperature is first diode result minus second diode result.
// - Temperature code offset from Kelvin to Celsius, 1/8 degree per code.
// - Result frame: four zeros then 12-bit result, MSB first.
// - Sample input on rising serial clock, change output on falling.
// - Modes 00/01 start from pin; 10/11 start on conversion byte.
// - Unipolar results straight binary, bipolar results two's complement.
// - Pair flagged both unipolar and bipolar is treated as unipolar.
`timescale 1ns/100ps
module adc_setup_and_pair_config
  import adc_cfg_pkg::*;
#(
  parameter int PAIRS_PRESENT = 8,
  parameter int REF_WAKE_CYCLES = REF_WAKE_CYC
)(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic sdi_i,
  input wire logic convert_start_pin_n_i,
  input wire logic scan_done_i,
  input wire logic result_valid_i,
  input wire logic [11:0] result_code_i,
  input wire logic result_is_temp_i,
  input wire logic [3:0] result_channel_i,
  input wire logic temp_first_valid_i,
  input wire logic [11:0] temp_first_i,
  input wire logic [11:0] temp_second_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  output logic conv_start_o,
  output logic int_clock_o,
  output logic ext_acq_timing_o,
  output logic sclk_conv_clock_o,
  output logic convert_start_pin_dedicated_o,
  output logic ref_internal_o,
  output logic ref_power_o,
  output logic ref_ready_o,
  output logic ref_neg_pin_o,
  output logic [NUM_PAIRS-1:0] uni_diff_o,
  output logic [NUM_PAIRS-1:0] bi_diff_o,
  output logic [7:0] unipolar_pair_select_o,
  output logic [7:0] bipolar_pair_select_o
);

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  logic [1:0] sclk_sync_reg;
  logic [1:0] cs_sync_reg;
  logic [1:0] sdi_sync_reg;
  logic [1:0] cnv_sync_reg;
  logic sclk_prev_reg;
  logic cnv_prev_reg;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sclk_sync_reg <= 2'h0;
      cs_sync_reg <= 2'h3;
      sdi_sync_reg <= 2'h0;
      cnv_sync_reg <= 2'h3;
      sclk_prev_reg <= 1'b0;
      cnv_prev_reg <= 1'b1;
    end
    else
    begin
      sclk_sync_reg <= {sclk_sync_reg[0], sclk_i};
      cs_sync_reg <= {cs_sync_reg[0], cs_n_i};
      sdi_sync_reg <= {sdi_sync_reg[0], sdi_i};
      cnv_sync_reg <= {cnv_sync_reg[0], convert_start_pin_n_i};
      sclk_prev_reg <= sclk_sync_reg[1];
      cnv_prev_reg <= cnv_sync_reg[1];
    end
  end

  logic sclk_s;
  logic cs_active;
  logic sclk_rise;
  logic sclk_fall;
  logic cnv_rise;
  assign sclk_s = sclk_sync_reg[1];
  assign cs_active = ~cs_sync_reg[1];
  assign sclk_rise = sclk_s & ~sclk_prev_reg & cs_active;
  assign sclk_fall = ~sclk_s & sclk_prev_reg & cs_active;
  assign cnv_rise = cnv_sync_reg[1] & ~cnv_prev_reg;

  // ==========================================================
  // Byte assembly on rising serial clock
  // ==========================================================
  logic [2:0] bit_cnt_reg;
  logic [6:0] shift_reg;
  logic byte_done;
  logic [7:0] rx_byte;
  assign byte_done = sclk_rise && (bit_cnt_reg == 3'h7);
  assign rx_byte = {shift_reg, sdi_sync_reg[1]};

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      bit_cnt_reg <= 3'h0;
      shift_reg <= 7'h00;
    end
    else if (!cs_active)
    begin
      bit_cnt_reg <= 3'h0;
    end
    else if (sclk_rise)
    begin
      shift_reg <= rx_byte[6:0];
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
    end
  end

  // ==========================================================
  // Command decode and configuration registers
  // ==========================================================
  rx_state_e rx_state_reg;
  setup_s setup_reg;
  logic [7:0] uni_reg;
  logic [7:0] bi_reg;
  logic is_setup;
  logic is_conv;
  assign is_setup = !rx_byte[CMD_HI_BIT] && rx_byte[CMD_SETUP_BIT];
  assign is_conv = rx_byte[CMD_HI_BIT];

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rx_state_reg <= RX_CMD;
      setup_reg <= setup_s'(SETUP_RESET[5:0]);
      uni_reg <= PAIR_RESET;
      bi_reg <= PAIR_RESET;
    end
    else if (!cs_active)
    begin
      rx_state_reg <= RX_CMD;
    end
    else if (byte_done)
    begin
      unique case (rx_state_reg)
        RX_CMD:
        begin
          if (is_setup)
          begin
            setup_reg.clock_mode <= rx_byte[CLK_HI_BIT:CLK_LO_BIT];
            setup_reg.vref_select <= rx_byte[REF_HI_BIT:REF_LO_BIT];
            setup_reg.pair_reg_select <= rx_byte[PAIR_HI_BIT:PAIR_LO_BIT];
            // High select bit clear: next byte is a fresh command
            if (rx_byte[PAIR_HI_BIT])
              rx_state_reg <= RX_PAIR;
          end
          else if (is_conv && setup_reg.clock_mode == CLK_SER_SER)
            rx_state_reg <= RX_SKIP;
        end
        RX_PAIR:
        begin
          if (setup_reg.pair_reg_select == PAIR_UNI)
            uni_reg <= rx_byte;
          else
            bi_reg <= rx_byte;
          rx_state_reg <= RX_CMD;
        end
        RX_SKIP:
          rx_state_reg <= RX_CMD;
      endcase
    end
  end

  // ==========================================================
  // Clock mode, conversion start and reference control
  // ==========================================================
  logic pin_mode;
  logic ref_wake_needed;
  logic [$clog2(REF_WAKE_CYCLES+1)-1:0] wake_cnt_reg;
  assign pin_mode = !setup_reg.clock_mode[1];
  assign ref_wake_needed = setup_reg.vref_select == REF_INT_AUTO;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      conv_start_o <= 1'b0;
      int_clock_o <= 1'b1;
      ext_acq_timing_o <= 1'b0;
      sclk_conv_clock_o <= 1'b0;
      convert_start_pin_dedicated_o <= 1'b0;
    end
    else
    begin
      conv_start_o <= pin_mode ? cnv_rise
        : (byte_done && rx_state_reg == RX_CMD && is_conv);
      int_clock_o <= setup_reg.clock_mode != CLK_SER_SER;
      ext_acq_timing_o <= setup_reg.clock_mode == CLK_INT_EXT;
      sclk_conv_clock_o <= setup_reg.clock_mode == CLK_SER_SER;
      convert_start_pin_dedicated_o <= pin_mode;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ref_internal_o <= 1'b0;
      ref_power_o <= 1'b0;
      ref_ready_o <= 1'b0;
      ref_neg_pin_o <= 1'b0;
      wake_cnt_reg <= '0;
    end
    else
    begin
      ref_internal_o <= !setup_reg.vref_select[0];
      ref_neg_pin_o <= setup_reg.vref_select == REF_EXT_DIFF;
      if (setup_reg.vref_select == REF_INT_ON)
        ref_power_o <= 1'b1;
      else if (ref_wake_needed && conv_start_o)
        ref_power_o <= 1'b1;
      else if (!ref_wake_needed || scan_done_i)
        ref_power_o <= 1'b0;
      if (!ref_wake_needed)
      begin
        ref_ready_o <= 1'b1;
        wake_cnt_reg <= '0;
      end
      else if (!ref_power_o || scan_done_i)
      begin
        ref_ready_o <= 1'b0;
        wake_cnt_reg <= '0;
      end
      else if (wake_cnt_reg == ($bits(wake_cnt_reg))'(REF_WAKE_CYCLES))
        ref_ready_o <= 1'b1;
      else
        wake_cnt_reg <= wake_cnt_reg + 1'b1;
    end
  end

  // ==========================================================
  // Pair decode for the conversion logic
  // ==========================================================
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      uni_diff_o <= '0;
      bi_diff_o <= '0;
      unipolar_pair_select_o <= PAIR_RESET;
      bipolar_pair_select_o <= PAIR_RESET;
    end
    else
    begin
      unipolar_pair_select_o <= uni_reg;
      bipolar_pair_select_o <= bi_reg;
      for (int p = 0; p < NUM_PAIRS; p++)
      begin
        // Index p is pair of inputs 2p and 2p+1; bit 7 is pair 0
        uni_diff_o[p] <= uni_reg[7-p] && (p < PAIRS_PRESENT);
        bi_diff_o[p] <= bi_reg[7-p] && !uni_reg[7-p]
          && (p < PAIRS_PRESENT);
      end
    end
  end

  // ==========================================================
  // Result formatting and serial output
  // ==========================================================
  logic [11:0] temp_diff_reg;
  logic [11:0] out_code;
  logic chan_bipolar;
  logic [FRAME_BITS-1:0] frame_reg;
  logic [3:0] pair_idx;
  assign pair_idx = {1'b0, result_channel_i[3:1]};
  assign chan_bipolar = bi_diff_o[pair_idx[2:0]];
  assign out_code = result_is_temp_i
    ? temp_diff_reg - TEMP_OFFSET
    : (chan_bipolar ? result_code_i ^ 12'h800 : result_code_i);

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      temp_diff_reg <= 12'h000;
    else if (temp_first_valid_i)
      temp_diff_reg <= temp_first_i - temp_second_i;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      frame_reg <= '0;
      sdo_o <= 1'b0;
      sdo_oe_o <= 1'b0;
    end
    else
    begin
      sdo_oe_o <= cs_active;
      // Leading bit goes out at once; falls then present the rest
      if (result_valid_i)
      begin
        sdo_o <= 1'b0;
        frame_reg <= {{(LEAD_ZEROS-1){1'b0}}, out_code, 1'b0};
      end
      else if (sclk_fall)
      begin
        sdo_o <= frame_reg[FRAME_BITS-1];
        frame_reg <= {frame_reg[FRAME_BITS-2:0], 1'b0};
      end
    end
  end

endmodule

// File: verification/adc_setup_and_pair_config_props.sv
// Checker for setup decode, pair configuration and serial output
`timescale 1ns/100ps
module adc_cfg_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic convert_start_pin_n_i,
  input wire logic sclk_i,
  input wire logic sdo_o,
  input wire logic cs_n_i,
  input wire logic sdo_oe_o,
  input wire logic conv_start_o,
  input wire logic int_clock_o,
  input wire logic ext_acq_timing_o,
  input wire logic sclk_conv_clock_o,
  input wire logic convert_start_pin_dedicated_o,
  input wire logic ref_internal_o,
  input wire logic ref_power_o,
  input wire logic ref_neg_pin_o,
  input wire logic [7:0] uni_diff_o,
  input wire logic [7:0] bi_diff_o,
  input wire logic [7:0] unipolar_pair_select_o,
  input wire logic [7:0] bipolar_pair_select_o
);
  logic [7:0] uni_rev;
  logic [7:0] bi_rev;
  assign uni_rev = {<<{unipolar_pair_select_o}};
  assign bi_rev = {<<{bipolar_pair_select_o}};
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ====================
  // Decode relations, start pulse, select and serial output timing
  a_sclk_clock_mode: assert property (
    sclk_conv_clock_o |-> !int_clock_o && !convert_start_pin_dedicated_o)
    else $error("serial clock mode with internal clock");
  a_pin_mode_int: assert property (
    convert_start_pin_dedicated_o |-> int_clock_o)
    else $error("pin mode without internal clock");
  a_ext_acq_pin: assert property (
    ext_acq_timing_o |-> convert_start_pin_dedicated_o)
    else $error("pin timed acquisition without pin");
  a_ref_neg_ext: assert property (
    ref_neg_pin_o |-> !ref_internal_o)
    else $error("negative reference pin with internal reference");
  a_ref_power_int: assert property (
    ref_power_o |-> ref_internal_o)
    else $error("reference powered while external");
  a_uni_pair_map: assert property (
    uni_diff_o == uni_rev)
    else $error("unipolar pair map wrong");
  a_bi_pair_map: assert property (
    bi_diff_o == (bi_rev & ~uni_rev))
    else $error("bipolar pair map wrong");
  a_sdo_on_fall: assert property (
    $changed(sdo_o) |-> !sclk_i)
    else $error("serial output moved while clock high");
  a_pin_start: assert property (
    $rose(convert_start_pin_n_i) && convert_start_pin_dedicated_o
      |-> ##[1:8] conv_start_o)
    else $error("pin rise did not start conversion");
  a_start_pulse: assert property (
    conv_start_o |=> !conv_start_o)
    else $error("start pulse longer than one cycle");
  a_oe_with_cs: assert property (
    $fell(cs_n_i) |-> ##[1:4] sdo_oe_o)
    else $error("serial output not enabled after select");
endmodule

bind adc_setup_and_pair_config adc_cfg_checker props (.clk_i, .rst_i,
  .convert_start_pin_n_i, .sclk_i, .sdo_o, .cs_n_i, .sdo_oe_o,
  .conv_start_o, .int_clock_o,
  .ext_acq_timing_o, .sclk_conv_clock_o, .convert_start_pin_dedicated_o,
  .ref_internal_o, .ref_power_o, .ref_neg_pin_o, .uni_diff_o, .bi_diff_o,
  .unipolar_pair_select_o, .bipolar_pair_select_o);

// File: verification/spi_host_model.sv
// Serial host model driving the setup port
`timescale 1ns/100ps
module spi_host_model (
  output logic sclk_o,
  output logic cs_n_o,
  output logic sdi_o,
  input wire logic sdo_i
);
  initial
  begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o = 1'b1;
  end
  // ====================
  // One frame, MSB first, clock idle low
  task automatic frame(input logic [15:0] tx, input int n,
    output logic [15:0] rx);
    rx = 16'h0000;
    #37 cs_n_o = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      sdi_o = tx[15-i];
      #100 sclk_o = 1'b1;
      rx = {rx[14:0], sdo_i};
      #100 sclk_o = 1'b0;
    end
    #100 cs_n_o = 1'b1;
    sdi_o = ~sdi_o;
    #1000;
  endtask
endmodule

// File: verification/adc_setup_and_pair_config_tb.sv
// Testbench for setup decode, pair registers and result framing
`timescale 1ns/100ps
module adc_setup_and_pair_config_tb import adc_cfg_pkg::*;;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic sclk_i, cs_n_i, sdi_i, sdo_o, sdo_oe_o, conv_start_o;
  logic convert_start_pin_n_i, scan_done_i, result_valid_i;
  logic result_is_temp_i, temp_first_valid_i, int_clock_o, ref_ready_o;
  logic ext_acq_timing_o, sclk_conv_clock_o, convert_start_pin_dedicated_o;
  logic ref_internal_o, ref_power_o, ref_neg_pin_o;
  logic [11:0] result_code_i, temp_first_i, temp_second_i;
  logic [3:0] result_channel_i;
  logic [7:0] uni_diff_o, bi_diff_o;
  logic [7:0] unipolar_pair_select_o, bipolar_pair_select_o;
  int error_cnt = 0;
  int tests_run = 0;
  int starts = 0;
  always #12.5 clk_i = ~clk_i;
  adc_setup_and_pair_config #(.REF_WAKE_CYCLES(10)) dut (
    .clk_i, .rst_i, .sclk_i, .cs_n_i, .sdi_i, .convert_start_pin_n_i,
    .scan_done_i, .result_valid_i, .result_code_i, .result_is_temp_i,
    .result_channel_i, .temp_first_valid_i, .temp_first_i, .temp_second_i,
    .sdo_o, .sdo_oe_o, .conv_start_o, .int_clock_o, .ext_acq_timing_o,
    .sclk_conv_clock_o, .convert_start_pin_dedicated_o, .ref_internal_o,
    .ref_power_o, .ref_ready_o, .ref_neg_pin_o, .uni_diff_o, .bi_diff_o,
    .unipolar_pair_select_o, .bipolar_pair_select_o);
  spi_host_model host (.sclk_o(sclk_i), .cs_n_o(cs_n_i), .sdi_o(sdi_i),
    .sdo_i(sdo_o));
  always @(posedge clk_i)
  begin
    if (conv_start_o === 1'b1)
      starts <= starts + 1;
  end
  // ====================
  // Shared tasks
  task automatic chk(input string what, input logic [15:0] got, exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [15:0] b, input int n);
    logic [15:0] d;
    host.frame(b, n, d);
  endtask
  task automatic pulse_pin();
    @(posedge clk_i) #2 convert_start_pin_n_i = 1'b0;
    repeat (4) @(posedge clk_i);
    #2 convert_start_pin_n_i = 1'b1;
    repeat (12) @(posedge clk_i);
  endtask
  task automatic wrap_up();
    if (error_cnt == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ====================
  // Scenarios
  task automatic t_modes();
    logic [1:0] m, r;
    for (int i = 0; i < 16; i++)
    begin
      {m, r} = 4'(i);
      wr({2'b01, m, r, 2'b00, 8'h00}, 8);
      chk("clock", {int_clock_o, ext_acq_timing_o, sclk_conv_clock_o,
        convert_start_pin_dedicated_o},
        {m != 2'h3, m == 2'h1, m == 2'h3, !m[1]});
      chk("ref", {ref_internal_o, ref_neg_pin_o}, {!r[0], r == 2'h3});
      if (r == 2'h2)
        chk("ref on", {ref_power_o, ref_ready_o}, 2'b11);
    end
  endtask
  task automatic t_pairs();
    wr(16'h62C4, 16);
    wr(16'h63FF, 16);
    chk("uni reg", unipolar_pair_select_o, 8'hC4);
    chk("bi reg", bipolar_pair_select_o, 8'hFF);
    chk("uni pairs", uni_diff_o, 8'h23);
    chk("bi pairs", bi_diff_o, 8'hDC);
    wr(16'h6833, 16);
    wr(16'h6900, 8);
    wr(16'h3000, 8);
    chk("kept", {unipolar_pair_select_o, bipolar_pair_select_o}, 16'hC4FF);
    chk("not setup", {int_clock_o, sclk_conv_clock_o}, 2'b10);
  endtask
  task automatic t_conv();
    int s;
    wr(16'h6000, 8);
    s = starts;
    pulse_pin();
    chk("pin ignored", 16'(starts - s), 16'h0000);
    wr(16'h8600, 8);
    chk("byte start", 16'(starts - s), 16'h0001);
    chk("ref up", {ref_power_o, ref_ready_o}, 2'b11);
    @(posedge clk_i) #2 scan_done_i = 1'b1;
    @(posedge clk_i) #2 scan_done_i = 1'b0;
    repeat (4) @(posedge clk_i);
    chk("ref down", {ref_power_o, ref_ready_o}, 2'b00);
    wr(16'h4000, 8);
    wr(16'h8600, 8);
    pulse_pin();
    chk("pin start", 16'(starts - s), 16'h0002);
  endtask
  task automatic t_res(input logic [11:0] c, input logic tmp,
    input logic [3:0] ch, input logic [15:0] exp);
    logic [15:0] d;
    @(posedge clk_i) #2 result_valid_i = 1'b1;
    result_code_i = c;
    result_is_temp_i = tmp;
    result_channel_i = ch;
    @(posedge clk_i) #2 result_valid_i = 1'b0;
    host.frame(16'h0000, 16, d);
    chk("frame", d, exp);
  endtask
  // ====================
  // Main sequence
  initial
  begin
    convert_start_pin_n_i = 1'b1;
    scan_done_i = 1'b0;
    result_valid_i = 1'b0;
    result_is_temp_i = 1'b0;
    temp_first_valid_i = 1'b0;
    result_code_i = 12'h000;
    temp_first_i = 12'h900;
    temp_second_i = 12'h100;
    result_channel_i = 4'h0;
    repeat (12) @(posedge clk_i);
    #2 rst_i = 1'b0;
    repeat (4) @(posedge clk_i);
    chk("reset mode", {int_clock_o, sclk_conv_clock_o}, 2'b10);
    t_modes();
    t_pairs();
    t_conv();
    t_res(12'hABC, 1'b0, 4'h0, 16'h0ABC);
    t_res(12'h123, 1'b0, 4'h4, 16'h0923);
    @(posedge clk_i) #2 temp_first_valid_i = 1'b1;
    @(posedge clk_i) #2 temp_first_valid_i = 1'b0;
    t_res(12'h000, 1'b1, 4'h0, {4'h0, 12'h800 - TEMP_OFFSET});
    chk("oe idle", sdo_oe_o, 1'b0);
    wrap_up();
  end
  // Run needs about 90 us; allow about eleven times that
  initial
  begin
    #1_000_000;
    error_cnt++;
    wrap_up();
  end
endmodule
